/* File: rtl/wdt_pkg.sv */
package wdt_pkg;
    // Register offsets (word index on the plain port)
    localparam logic [1:0] OFF_CTRL  = 2'h0;
    localparam logic [1:0] OFF_CAUSE = 2'h1;
    localparam logic [1:0] OFF_STAT  = 2'h2;
    localparam logic [1:0] OFF_MASK  = 2'h3;
    // Field positions
    localparam int CAUSE_WATCHDOG_RESET_FLAG_BIT = 3;
    localparam int STAT_IRQ_BIT   = 0;
    localparam int STAT_RST_BIT   = 1;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] STAT_RST = 2'h0;
    // Timing
    localparam int OSC_HZ          = 128000;  // Oscillator rate
    localparam int TMO_MIN_MS      = 16;      // Shortest period, about
    localparam int TMO_MAX_S       = 8;       // Longest period, about
    localparam int BASE_OSC_CYC    = 2048;    // Code 0 period in ticks
    localparam logic [3:0] SEL_MAX = 4'h9;    // Highest defined code
    localparam int CLK_PERIOD_NS   = 25;      // System clock period
    localparam int UNLOCK_WIN_CYC  = 4;       // Unlock window, clocks
    localparam logic [2:0] WIN_LOAD = 3'(UNLOCK_WIN_CYC);
    // Control register layout
    typedef struct packed {
        logic       flag;     // timeout_irq_flag
        logic       irq_en;   // timeout_irq_enable
        logic       sel3;     // prescaler_select[3]
        logic       chg_en;   // change_enable_bit
        logic       rst_en;   // reset_enable_bit
        logic [2:0] sel_lo;   // prescaler_select[2:0]
    } ctrl_t;
endpackage : wdt_pkg

/* File: rtl/enhanced_watchdog_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module enhanced_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int BASE_CYC = BASE_OSC_CYC   // Ticks at code 0
)(
    input  wire logic       clock,         // 40 MHz system clock
    input  wire logic       rst_b,         // Power-on reset, low
    input  wire logic       osc_in,        // 128 kHz oscillator
    input  wire logic       always_on_fuse,// Fuse programmed
    input  wire logic       restart,       // Restart instruction
    input  wire logic       irq_ack,       // Vector taken
    input  wire logic [1:0] addr,          // Register index
    input  wire logic [7:0] wdata,         // Write data
    input  wire logic       wr,            // Write strobe
    input  wire logic       rd,            // Read strobe
    output logic      [7:0] rdata,         // Read data, next cycle
    output logic            wdt_irq,       // Watchdog interrupt
    output logic            sys_reset,     // One-cycle reset pulse
    output logic            irq            // Status/mask interrupt
);
    // Synchroniser and edge detector for the oscillator
    logic        osc_meta_r;   // First stage, read only by second
    logic        osc_sync_r;   // Second stage
    logic        osc_prev_r;   // Delayed copy for edge
    logic        tick;         // One oscillator cycle seen
    // Control state
    logic        flag_r;       // Timeout interrupt flag
    logic        irq_en_r;     // Interrupt enable as written
    logic        rst_en_r;     // Reset enable as written
    logic [3:0]  sel_r;        // Prescaler select
    logic [2:0]  win_r;        // Unlock window count
    logic        watchdog_reset_flag_r;       // Watchdog reset flag
    logic [1:0]  stat_r;       // Sticky events
    logic [1:0]  mask_r;       // Event mask
    logic [20:0] cnt_r;        // Watchdog counter
    logic [7:0]  rdata_r;      // Read data register
    logic        sys_reset_r;  // Reset pulse register
    // Derived
    logic        eff_rst;      // Reset enable as it acts
    logic        eff_irq;      // Interrupt enable as it acts
    logic        running;      // Counter active
    logic        tmo;          // Expiry this cycle
    logic        do_reset;     // Expiry leads to reset
    logic        ctl_wr;       // Write to control
    logic        win_open;     // Unlock window open
    ctrl_t       w;            // Written control value
    ctrl_t       ctl_view;     // Control as read

    // Expiry count for a select code; reserved codes act as the top one
    function automatic logic [20:0] tmo_limit(input logic [3:0] s);
        logic [3:0] c;
        c = (s > SEL_MAX) ? SEL_MAX : s;
        return 21'(BASE_CYC) << c;
    endfunction : tmo_limit

    // Oscillator crossing; the first stage feeds nothing else
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end
        else
        begin
            osc_meta_r <= osc_in;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end
    assign tick = osc_sync_r & ~osc_prev_r;

    // Fuse overrides both written enables; reset flag forces only the reset enable
    assign eff_rst  = rst_en_r | always_on_fuse | watchdog_reset_flag_r;
    assign eff_irq  = irq_en_r & ~always_on_fuse;
    assign running  = eff_rst | eff_irq;
    assign w        = ctrl_t'(wdata);
    assign ctl_wr   = wr && (addr == OFF_CTRL);
    assign win_open = (win_r != 3'h0);

    // Expiry; >= catches a shorter period chosen mid-count
    assign tmo = tick && running && (cnt_r >= tmo_limit(sel_r) - 21'h1);
    // Combined mode takes its interrupt first; with the flag still
    // pending the next expiry resets
    assign do_reset = tmo && eff_rst && !(eff_irq && !flag_r);

    // Watchdog counter
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            cnt_r <= 21'h0;
        else if (restart || !running || tmo)
            cnt_r <= 21'h0;
        else if (tick)
            cnt_r <= cnt_r + 21'h1;
    end

    // Enables, prescaler and unlock window
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_en_r <= CTRL_RST[3];
            irq_en_r <= CTRL_RST[6];
            sel_r    <= {CTRL_RST[5], CTRL_RST[2:0]};
            win_r    <= 3'h0;
        end
        else
        begin
            if (ctl_wr)
            begin
                irq_en_r <= w.irq_en;
                if (w.chg_en && w.rst_en)
                begin
                    // Unlock write opens the window
                    win_r    <= WIN_LOAD;
                    rst_en_r <= 1'b1;
                end
                else if (win_open && !w.chg_en)
                begin
                    // Timed write applies and closes the window
                    rst_en_r <= w.rst_en | watchdog_reset_flag_r;
                    sel_r    <= {w.sel3, w.sel_lo};
                    win_r    <= 3'h0;
                end
                else
                begin
                    // Outside the window, or with change enable set alone, only setting the enable counts
                    if (w.rst_en)
                        rst_en_r <= 1'b1;
                    if (win_open)
                        win_r <= win_r - 3'h1;
                end
            end
            else if (win_open)
                win_r <= win_r - 3'h1;
            // Vectoring in combined mode drops back to reset mode
            if (irq_ack && eff_rst && eff_irq)
                irq_en_r <= 1'b0;
        end
    end

    // Timeout interrupt flag; a new expiry beats a clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            flag_r <= CTRL_RST[7];
        else if (tmo && eff_irq)
            flag_r <= 1'b1;
        else if (irq_ack || (ctl_wr && w.flag))
            flag_r <= 1'b0;
    end
    assign wdt_irq = flag_r & eff_irq;

    // Reset pulse and watchdog reset flag; power-on or a CAUSE write with bit 3 clear clears it
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sys_reset_r <= 1'b0;
            watchdog_reset_flag_r      <= 1'b0;
        end
        else
        begin
            sys_reset_r <= do_reset;
            if (sys_reset_r)
                watchdog_reset_flag_r <= 1'b1;
            else if (wr && addr == OFF_CAUSE && !wdata[CAUSE_WATCHDOG_RESET_FLAG_BIT])
                watchdog_reset_flag_r <= 1'b0;
        end
    end
    assign sys_reset = sys_reset_r;

    // Sticky events, write one to clear, set wins
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stat_r <= STAT_RST;
            mask_r <= STAT_RST;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if ((i == STAT_IRQ_BIT && tmo && eff_irq) ||
                    (i == STAT_RST_BIT && do_reset))
                    stat_r[i] <= 1'b1;
                else if (wr && addr == OFF_STAT && wdata[i])
                    stat_r[i] <= 1'b0;
            end
            if (wr && addr == OFF_MASK)
                mask_r <= wdata[1:0];
        end
    end
    assign irq = |(stat_r & mask_r);

    // Control register as software sees it
    always_comb
    begin
        ctl_view        = '0;
        ctl_view.flag   = flag_r;
        ctl_view.irq_en = eff_irq;
        ctl_view.sel3   = sel_r[3];
        ctl_view.chg_en = win_open;
        ctl_view.rst_en = eff_rst;
        ctl_view.sel_lo = sel_r[2:0];
    end

    // Read data one cycle after the strobe; holds zero otherwise
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rdata_r <= 8'h00;
        else if (!rd)
            rdata_r <= 8'h00;
        else
        begin
            case (addr)
                OFF_CTRL:  rdata_r <= ctl_view;
                OFF_CAUSE: rdata_r <= 8'(watchdog_reset_flag_r) << CAUSE_WATCHDOG_RESET_FLAG_BIT;
                OFF_STAT:  rdata_r <= {6'h00, stat_r};
                OFF_MASK:  rdata_r <= {6'h00, mask_r};
                default:   rdata_r <= 8'h00;
            endcase
        end
    end
    assign rdata = rdata_r;

    // Checks
    sequence s_unlock;
        ctl_wr && w.chg_en && w.rst_en;
    endsequence
    sequence s_locked_wr;
        ctl_wr && !win_open && !(w.chg_en && w.rst_en);
    endsequence
    // Timed write: lands inside the window with change enable clear
    sequence s_apply;
        ctl_wr && win_open && !w.chg_en;
    endsequence

    a_window_close: assert property (@(posedge clock) disable iff (!rst_b)
        s_unlock ##1 !ctl_wr [*4] |=> !win_open)
        else $error("change enable outlived its window");
    a_window_open: assert property (@(posedge clock) disable iff (!rst_b)
        s_unlock |=> win_open && eff_rst)
        else $error("unlock write did not open window");
    a_locked_sel: assert property (@(posedge clock) disable iff (!rst_b)
        s_locked_wr |=> $stable(sel_r))
        else $error("prescaler changed without unlock");
    a_locked_clear: assert property (@(posedge clock) disable iff (!rst_b)
        (s_locked_wr and rst_en_r) |=> rst_en_r)
        else $error("reset enable cleared without unlock");
    a_fuse_lock: assert property (@(posedge clock) disable iff (!rst_b)
        always_on_fuse |-> eff_rst && !eff_irq && !wdt_irq)
        else $error("fuse did not force reset mode");
    a_reset_flag: assert property (@(posedge clock) disable iff (!rst_b)
        sys_reset |=> watchdog_reset_flag_r ##0 eff_rst ##1 !sys_reset)
        else $error("watchdog reset not recorded");
    a_irq_first: assert property (@(posedge clock) disable iff (!rst_b)
        tmo && eff_irq && !flag_r |-> !do_reset ##1 flag_r && !sys_reset)
        else $error("combined mode reset before interrupt");
    a_restart_cnt: assert property (@(posedge clock) disable iff (!rst_b)
        restart |=> cnt_r == 21'h0)
        else $error("restart did not clear counter");
    a_reset_mode: assert property (@(posedge clock) disable iff (!rst_b)
        tmo && eff_rst && !eff_irq |=> sys_reset)
        else $error("reset mode expiry gave no reset");

    // Counter holds at zero when stopped and steps once per tick
    a_stopped_cnt: assert property (@(posedge clock) disable iff (!rst_b)
        !running |-> !tmo ##1 cnt_r == 21'h0)
        else $error("stopped watchdog counted or expired");
    a_tick_step: assert property (@(posedge clock) disable iff (!rst_b)
        tick && running && !restart && !tmo |=> cnt_r == $past(cnt_r) + 21'h1)
        else $error("counter missed an oscillator tick");
    a_idle_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !tick && running && !restart |=> $stable(cnt_r))
        else $error("counter moved without a tick");

    // Flag and sticky status bookkeeping; a new event beats a clear
    a_irq_mode: assert property (@(posedge clock) disable iff (!rst_b)
        tmo && eff_irq |=> flag_r && stat_r[STAT_IRQ_BIT])
        else $error("expiry in interrupt mode set no flag");
    a_flag_clear: assert property (@(posedge clock) disable iff (!rst_b)
        irq_ack && !(tmo && eff_irq) |=> !flag_r)
        else $error("vectoring left the flag set");
    a_reset_event: assert property (@(posedge clock) disable iff (!rst_b)
        do_reset |=> sys_reset && stat_r[STAT_RST_BIT])
        else $error("reset expiry not recorded as an event");

    // Timed write outcome, reset flag override and fuse view
    a_apply_sel: assert property (@(posedge clock) disable iff (!rst_b)
        s_apply |=> !win_open && sel_r[2:0] == $past(wdata[2:0]))
        else $error("timed write not applied");
    a_flag_keeps: assert property (@(posedge clock) disable iff (!rst_b)
        (s_apply and watchdog_reset_flag_r) |=> rst_en_r)
        else $error("reset enable cleared while reset flag set");
    a_fuse_view: assert property (@(posedge clock) disable iff (!rst_b)
        always_on_fuse |-> ctl_view.rst_en && !ctl_view.irq_en)
        else $error("fuse not visible in control view");
endmodule : enhanced_watchdog_timer
`default_nettype wire

/* File: tb/wdt_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Dedicated low-rate oscillator; runs free and knows nothing of the system clock
module wdt_osc_model
#(
    parameter real HALF_NS = 3906.25   // Half period at 128 kHz
)(
    output logic osc                   // Oscillator level
);
    // Odd start offset keeps its edges unrelated to the system clock
    initial
    begin
        osc = 1'b0;
        #1003.3;
        forever #HALF_NS osc = ~osc;
    end
endmodule : wdt_osc_model
`default_nettype wire

/* File: tb/enhanced_watchdog_timer_test.sv */
`timescale 1ns/10ps
`default_nettype none
module enhanced_watchdog_timer_test import wdt_pkg::*;;
    logic       clock = 1'b0;          // System clock
    logic       rst_b = 1'b0;          // Reset, active low
    logic       osc_in;                // Oscillator level
    logic       always_on_fuse = 1'b0; // Fuse state
    logic       restart = 1'b0;        // Restart instruction
    logic       irq_ack = 1'b0;        // Vector taken
    logic       wr = 1'b0;             // Write strobe
    logic       rd = 1'b0;             // Read strobe
    logic [1:0] addr = 2'h0;           // Register index
    logic [7:0] wdata = 8'h00;         // Write data
    logic [7:0] rdata;                 // Read data
    logic [7:0] d;                     // Random control value
    logic       wdt_irq;               // Watchdog interrupt
    logic       sys_reset;             // Reset pulse
    logic       irq;                   // Status interrupt
    int         miscompares = 0;       // Mismatches
    int         tests_run = 0;         // Comparisons
    int         n_rst = 0;             // Reset pulses seen
    int         m_rst = 0;             // Reset pulses the model expects

    initial forever #12.5 clock = ~clock;

    wdt_osc_model osc (.osc(osc_in));

    // Short base period keeps each expiry at four oscillator ticks
    enhanced_watchdog_timer #(.BASE_CYC(4)) dut (.clock(clock), .rst_b(rst_b),
        .osc_in(osc_in), .always_on_fuse(always_on_fuse), .restart(restart),
        .irq_ack(irq_ack), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .wdt_irq(wdt_irq), .sys_reset(sys_reset), .irq(irq));

    // The pulse stands one cycle only, so it is counted at every edge
    always @(posedge clock) if (sys_reset === 1'b1) n_rst <= n_rst + 1;

    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_reg

    // Timed pair: opening write, then the applying write inside the window
    task unlock(input logic [7:0] v);
        wr_reg(OFF_CTRL, 8'h18);
        wr_reg(OFF_CTRL, v);
    endtask : unlock

    task pulse(input bit ack);
        @(posedge clock);
        if (ack) irq_ack <= 1'b1;
        else restart <= 1'b1;
        @(posedge clock);
        irq_ack <= 1'b0;
        restart <= 1'b0;
    endtask : pulse

    // Margin covers the synchroniser and the flag or pulse register
    task ticks(input int n);
        repeat (n) @(posedge osc_in);
        repeat (8) @(posedge clock);
        #1;
    endtask : ticks

    // Restart just after a tick has landed, so no tick in flight is lost
    task sync_restart;
        @(posedge osc_in);
        repeat (5) @(posedge clock);
        pulse(1'b0);
    endtask : sync_restart

    task close_out;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // About thirty ticks are needed; four times that span means a hang
    initial
    begin
        #1000000;
        miscompares++;
        close_out();
    end

    initial
    begin
        void'($urandom(32'h2c73));
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        rd_reg(OFF_CTRL, CTRL_RST);
        rd_reg(OFF_CAUSE, 8'h00);
        rd_reg(OFF_STAT, 8'h00);
        pulse(1'b0);
        // Plain writes may set the enable but never move the select
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($urandom) & 8'hE7;
            wr_reg(OFF_CTRL, d);
            rd_reg(OFF_CTRL, d & 8'h40);
        end
        wr_reg(OFF_CTRL, 8'h00);
        wr_reg(OFF_CTRL, 8'h18);
        rd_reg(OFF_CTRL, 8'h18);
        repeat (6) @(posedge clock);
        rd_reg(OFF_CTRL, 8'h08);
        wr_reg(OFF_CTRL, 8'h00);
        rd_reg(OFF_CTRL, 8'h08);
        unlock(8'h40);
        rd_reg(OFF_CTRL, 8'h40);
        wr_reg(OFF_MASK, 8'h01);
        sync_restart();
        ticks(3);
        chk({7'h0, wdt_irq}, 8'h00);
        pulse(1'b0);
        ticks(3);
        chk({7'h0, wdt_irq}, 8'h00);
        ticks(1);
        chk({7'h0, wdt_irq}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rd_reg(OFF_STAT, 8'h01);
        rd_reg(OFF_CTRL, 8'hC0);
        wr_reg(OFF_CTRL, 8'hC0);
        wr_reg(OFF_STAT, 8'h01);
        rd_reg(OFF_STAT, 8'h00);
        chk({wdt_irq, irq, 6'h0}, 8'h00);
        // Combined mode: first expiry interrupts, second resets
        wr_reg(OFF_CTRL, 8'hC8);
        sync_restart();
        ticks(4);
        chk({7'h0, wdt_irq}, 8'h01);
        chk(8'(n_rst), 8'(m_rst));
        ticks(4);
        m_rst++;
        chk(8'(n_rst), 8'(m_rst));
        rd_reg(OFF_CAUSE, 8'h08);
        wr_reg(OFF_CTRL, 8'hC8);
        sync_restart();
        ticks(4);
        chk({7'h0, wdt_irq}, 8'h01);
        pulse(1'b1);
        rd_reg(OFF_CTRL, 8'h08);
        sync_restart();
        unlock(8'h00);
        rd_reg(OFF_CTRL, 8'h08);
        wr_reg(OFF_CAUSE, 8'h00);
        unlock(8'h00);
        rd_reg(OFF_CTRL, 8'h00);
        rd_reg(OFF_CAUSE, 8'h00);
        // Reset events unmasked, then cleared with the irq event still masked
        wr_reg(OFF_MASK, 8'h02);
        rd_reg(OFF_MASK, 8'h02);
        chk({7'h0, irq}, 8'h01);
        wr_reg(OFF_STAT, 8'h02);
        rd_reg(OFF_MASK, 8'h02);
        chk({7'h0, irq}, 8'h00);
        @(posedge clock);
        always_on_fuse <= 1'b1;
        wr_reg(OFF_CTRL, 8'h40);
        rd_reg(OFF_CTRL, 8'h08);
        sync_restart();
        ticks(4);
        m_rst++;
        chk(8'(n_rst), 8'(m_rst));
        close_out();
    end
endmodule : enhanced_watchdog_timer_test
`default_nettype wire
